// ---- inc/scsh_params.svh ----
// Named constants for the serial command slave.
// Assumes inclusion by the package, the slave module, the master model and the bench.
`ifndef SCSH_PARAMS_SVH
`define SCSH_PARAMS_SVH
// ---------------------------------------------------------------
// Frame and buffers
// ---------------------------------------------------------------
`define SCSH_FRAME_LAST 3'h7
`define SCSH_BUF_DEPTH 8
`define SCSH_FILL_BYTE 8'hFF
`define SCSH_STATUS_LEN 6'h02
`define SCSH_CMD_STATUS 8'h00
`define SCSH_OP_STAT 2'h0
`define SCSH_OP_READ 2'h1
`define SCSH_OP_WRITE 2'h2
`define SCSH_OP_DUPLEX 2'h3
// Pin order {clock, data, select}, idle clock and select high
`define SCSH_PIN_RST 3'h5
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SCSH_OFF_CTRL 8'h00
`define SCSH_OFF_TXCNT 8'h04
`define SCSH_OFF_STATUS 8'h08
`define SCSH_WIN_TX 3'h1
`define SCSH_WIN_RX 3'h2
`define SCSH_CTRL_RST 1'h1
`define SCSH_TXCNT_RST 4'h0
`endif

// ---- inc/scsh_pkg.sv ----
// Types shared by the serial command slave.
// Assumes the constants header is on the include path.
`include "scsh_params.svh"
package scsh_pkg;
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_DECODE = 5'h04,
    ST_DATA = 5'h08,
    ST_DONE = 5'h10
  } scsh_state_t;
  typedef struct packed
  {
    logic [1:0] op;
    logic [5:0] count;
  } scsh_cmd_t;
  typedef struct packed
  {
    logic sclk;
    logic sdi;
    logic csn;
  } scsh_pins_t;
endpackage

// ---- logic/scsh_slave.sv ----
// Serial command slave: select, busy handshake, command decode,
// eight-byte send and receive buffers, APB register access.
// Assumes the master clocks at most a few MHz against pclk.
// Function
// R1 - Every frame is exactly eight bits
// R2 - Shift most significant bit first
// R3 - Phase type 1: drive on fall, sample rise
// R4 - Shift only on the master's serial clock
// R5 - Data output disabled until selected
// R6 - Unselected: data and busy undriven
// R7 - Select falling edge: enable, busy low
// R8 - Command shifting starts: busy goes high
// R9 - Select high abandons exchange, back idle
// R10 - Each operation starts with command byte
// R11 - Top bits operation, low six count
// R12 - All-zero command is status check
// R13 - Status bytes: sendable 01, receivable 00
// R14 - Status check sends exactly two bytes
// R15 - Op 01 sends counted bytes
// R16 - Op 10 accepts counted bytes
// R17 - Op 11 exchanges counted bytes duplex
// R18 - Complement received bytes into send buffer
// R19 - After data phase rearm, busy low
// R20 - Send and receive buffers hold eight
// R21 - Master clocks only after busy low
// R22 - Completion flag after each received byte
//
// Register access over APB and the placing of the registers were left to the implementer.
`include "scsh_params.svh"
module scsh_slave (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic select_n,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic busy_out,
  output logic busy_oe
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  scsh_pkg::scsh_pins_t pin_s1_reg;
  scsh_pkg::scsh_pins_t pin_s2_reg;
  scsh_pkg::scsh_pins_t pin_s3_reg;
  scsh_pkg::scsh_pins_t pin_filt_reg;
  scsh_pkg::scsh_pins_t pin_prev_reg;
  scsh_pkg::scsh_pins_t pin_filt_next;
  scsh_pkg::scsh_pins_t pin_raw;
  wire [2:0] pin_agree;
  assign pin_raw = {serial_clock_in, serial_data_in, select_n};
  assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  // Filtered level moves only when stages two and three agree
  assign pin_filt_next = (pin_agree & pin_s2_reg) | (~pin_agree & pin_filt_reg);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_reg <= `SCSH_PIN_RST;
      pin_s2_reg <= `SCSH_PIN_RST;
      pin_s3_reg <= `SCSH_PIN_RST;
      pin_filt_reg <= `SCSH_PIN_RST;
      pin_prev_reg <= `SCSH_PIN_RST;
    end
    else
    begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_filt_reg <= pin_filt_next;
      pin_prev_reg <= pin_filt_reg;
    end
  end
  // Shift strobes come only from the master's clock, never our own
  wire sclk_rise = ~pin_prev_reg.sclk & pin_filt_reg.sclk; // R4
  wire sclk_fall = pin_prev_reg.sclk & ~pin_filt_reg.sclk; // R3
  wire cs_fall = pin_prev_reg.csn & ~pin_filt_reg.csn;
  wire selected = ~pin_filt_reg.csn;
  wire sdi_f = pin_filt_reg.sdi;
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  scsh_pkg::scsh_state_t state_reg;
  scsh_pkg::scsh_state_t state_next;
  scsh_pkg::scsh_cmd_t cmd_reg;
  logic busy_reg;
  logic busy_next;
  logic oe_reg;
  logic ctrl_en_reg;
  logic [3:0] tx_count_reg;
  logic [7:0] tx_buf [`SCSH_BUF_DEPTH];
  logic [7:0] rx_buf [`SCSH_BUF_DEPTH];
  logic [5:0] done_cnt_reg;
  logic [3:0] rx_n_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] shift_out_reg;
  logic [7:0] rx_byte_reg;
  logic frame_done_reg;
  logic sdo_reg;
  logic [31:0] prdata_reg;
  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire st_idle = state_reg == scsh_pkg::ST_IDLE;
  wire st_cmd = state_reg == scsh_pkg::ST_CMD;
  wire st_decode = state_reg == scsh_pkg::ST_DECODE;
  wire st_data = state_reg == scsh_pkg::ST_DATA;
  wire st_done = state_reg == scsh_pkg::ST_DONE;
  wire is_status = cmd_reg == `SCSH_CMD_STATUS; // R12
  wire op_rx = cmd_reg.op[1]; // R16
  // Op 00 with a nonzero count is not a command: it just rearms
  wire [5:0] data_len = is_status ? `SCSH_STATUS_LEN :
    (cmd_reg.op == `SCSH_OP_STAT) ? 6'h00 : cmd_reg.count; // R14
  wire [5:0] cnt_inc = done_cnt_reg + 6'h01;
  wire last_byte = cnt_inc == data_len;
  wire [5:0] pick_cnt = st_decode ? 6'h00 : cnt_inc;
  wire [7:0] stat_send = {`SCSH_OP_READ, 2'h0, tx_count_reg}; // R13
  wire [7:0] stat_recv = {`SCSH_OP_STAT, 6'(`SCSH_BUF_DEPTH)}; // R13
  wire [7:0] stat_byte = (pick_cnt == 6'h00) ? stat_send : stat_recv;
  // Status check shifts status bytes, write-only commands filler, others read the send buffer
  wire [7:0] pick_byte = is_status ? stat_byte :
    (cmd_reg.op == `SCSH_OP_WRITE) ? `SCSH_FILL_BYTE :
    tx_buf[pick_cnt[2:0]]; // R15 R17
  wire load_data = st_decode | (st_data & frame_done_reg & ~last_byte);
  wire load_fill = st_done | (st_cmd & frame_done_reg) | (st_data & frame_done_reg);
  // ---------------------------------------------------------------
  // Control state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    busy_next = busy_reg;
    if (!selected || !ctrl_en_reg)
    begin
      state_next = scsh_pkg::ST_IDLE; // R9
      busy_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        scsh_pkg::ST_IDLE:
        begin
          if (cs_fall)
          begin
            state_next = scsh_pkg::ST_CMD; // R7
            busy_next = 1'b0;
          end
        end
        scsh_pkg::ST_CMD:
        begin
          // First falling clock of the command raises busy
          if (sclk_fall)
            busy_next = 1'b1; // R8
          if (frame_done_reg)
            state_next = scsh_pkg::ST_DECODE; // R10
        end
        scsh_pkg::ST_DECODE:
        begin
          busy_next = 1'b0; // R21
          state_next = (data_len == 6'h00) ? scsh_pkg::ST_CMD : scsh_pkg::ST_DATA;
        end
        scsh_pkg::ST_DATA:
        begin
          if (frame_done_reg && last_byte)
          begin
            state_next = scsh_pkg::ST_DONE;
            busy_next = 1'b1;
          end
        end
        scsh_pkg::ST_DONE:
        begin
          state_next = scsh_pkg::ST_CMD; // R19
          busy_next = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= scsh_pkg::ST_IDLE;
      busy_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      oe_reg <= state_next != scsh_pkg::ST_IDLE; // R5 R6
    end
  end
  // ---------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      frame_done_reg <= 1'b0;
    end
    else
    begin
      frame_done_reg <= 1'b0;
      if (st_idle)
        bit_cnt_reg <= 3'h0;
      else if (sclk_rise)
      begin
        shift_in_reg <= {shift_in_reg[6:0], sdi_f}; // R2
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == `SCSH_FRAME_LAST)
        begin
          rx_byte_reg <= {shift_in_reg[6:0], sdi_f}; // R1
          frame_done_reg <= 1'b1; // R22
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_out_reg <= `SCSH_FILL_BYTE;
      sdo_reg <= 1'b1;
    end
    else if (st_idle)
    begin
      shift_out_reg <= `SCSH_FILL_BYTE;
      sdo_reg <= 1'b1;
    end
    else if (load_data)
      shift_out_reg <= pick_byte;
    else if (load_fill)
      shift_out_reg <= `SCSH_FILL_BYTE;
    else if (sclk_fall)
    begin
      sdo_reg <= shift_out_reg[7]; // R2 R3
      shift_out_reg <= {shift_out_reg[6:0], 1'b1};
    end
  end
  // ---------------------------------------------------------------
  // Command latch and receive buffer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg <= `SCSH_CMD_STATUS;
      done_cnt_reg <= 6'h00;
      rx_n_reg <= 4'h0;
    end
    else if (st_cmd && frame_done_reg)
      cmd_reg <= rx_byte_reg; // R11
    else if (st_decode)
    begin
      done_cnt_reg <= 6'h00;
      rx_n_reg <= 4'h0;
    end
    else if (st_data && frame_done_reg)
    begin
      done_cnt_reg <= cnt_inc;
      // Counts above the depth wrap; the tally stops at full
      if (op_rx && rx_n_reg != 4'(`SCSH_BUF_DEPTH))
        rx_n_reg <= rx_n_reg + 4'h1; // R20
    end
  end
  always_ff @(posedge pclk)
  begin
    if (st_data && frame_done_reg && op_rx)
      rx_buf[done_cnt_reg[2:0]] <= rx_byte_reg; // R16 R17
  end
  // ---------------------------------------------------------------
  // APB slave and send buffer
  // ---------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_ctrl = paddr == `SCSH_OFF_CTRL;
  wire hit_txcnt = paddr == `SCSH_OFF_TXCNT;
  wire hit_stat = paddr == `SCSH_OFF_STATUS;
  wire word_al = paddr[1:0] == 2'h0;
  wire hit_tx = (paddr[7:5] == `SCSH_WIN_TX) & word_al;
  wire hit_rx = (paddr[7:5] == `SCSH_WIN_RX) & word_al;
  wire addr_ok = hit_ctrl | hit_txcnt | hit_stat | hit_tx | hit_rx;
  wire apb_wr = apb_access & pwrite & addr_ok;
  wire [2:0] win_idx = paddr[4:2];
  wire [31:0] stat_word = {8'h00, cmd_reg, rx_n_reg, 3'h0,
    state_reg, 2'h0, busy_reg, selected};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_en_reg} :
    hit_txcnt ? {28'h0, tx_count_reg} :
    hit_stat ? stat_word :
    hit_tx ? {24'h0, tx_buf[win_idx]} :
    hit_rx ? {24'h0, rx_buf[win_idx]} : 32'h0;
  // Data is latched in setup so the zero-wait access sees a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0;
    else if (apb_setup && !pwrite)
      prdata_reg <= rd_mux;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_en_reg <= `SCSH_CTRL_RST;
      tx_count_reg <= `SCSH_TXCNT_RST;
    end
    else
    begin
      if (apb_wr && hit_ctrl)
        ctrl_en_reg <= pwdata[0];
      // Hardware refill wins over a software count write
      if (st_done && op_rx)
        tx_count_reg <= rx_n_reg; // R18
      else if (apb_wr && hit_txcnt)
        tx_count_reg <= pwdata[3:0];
    end
  end
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < `SCSH_BUF_DEPTH; i++)
    begin
      if (st_done && op_rx && 4'(i) < rx_n_reg)
        tx_buf[i] <= ~rx_buf[i]; // R18
      else if (apb_wr && hit_tx && win_idx == 3'(i))
        tx_buf[i] <= pwdata[7:0];
    end
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_ok;
  assign serial_data_out = sdo_reg;
  assign serial_data_out_oe = oe_reg; // R6
  assign busy_out = busy_reg;
  assign busy_oe = oe_reg; // R6
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_unsel_release: assert property (@(posedge pclk) disable iff (!presetn) // R6
    !selected |=> !serial_data_out_oe && !busy_oe)
    else $error("pins driven while unselected");
  a_select_ready: assert property (@(posedge pclk) disable iff (!presetn) // R7
    cs_fall && ctrl_en_reg && st_idle |=> serial_data_out_oe && busy_oe && !busy_out)
    else $error("select did not enable and lower busy");
  a_cmd_busy: assert property (@(posedge pclk) disable iff (!presetn) // R8
    st_cmd && sclk_fall && selected && ctrl_en_reg |=> busy_out)
    else $error("busy not raised on command clock");
  a_deselect_idle: assert property (@(posedge pclk) disable iff (!presetn) // R9
    $fell(selected) |=> st_idle ##1 !serial_data_out_oe)
    else $error("deselect did not abandon exchange");
  a_frame_eight: assert property (@(posedge pclk) disable iff (!presetn) // R1
    frame_done_reg |-> $past(bit_cnt_reg) == `SCSH_FRAME_LAST && bit_cnt_reg == 3'h0)
    else $error("frame not eight bits");
  a_msb_first: assert property (@(posedge pclk) disable iff (!presetn) // R2
    sclk_fall && !st_idle && !load_data && !load_fill |=> serial_data_out == $past(shift_out_reg[7]))
    else $error("output bit order wrong");
  a_cmd_latch: assert property (@(posedge pclk) disable iff (!presetn) // R11
    st_cmd && frame_done_reg |=> cmd_reg == $past(rx_byte_reg))
    else $error("command not latched");
  a_status_resp: assert property (@(posedge pclk) disable iff (!presetn) // R13
    st_decode && is_status && selected && ctrl_en_reg
    |=> shift_out_reg == {`SCSH_OP_READ, 2'h0, $past(tx_count_reg)})
    else $error("status byte wrong");
  a_status_two: assert property (@(posedge pclk) disable iff (!presetn) // R14
    st_data && is_status && frame_done_reg && done_cnt_reg == 6'h01 && selected && ctrl_en_reg
    |=> st_done)
    else $error("status check not two bytes");
  a_complement: assert property (@(posedge pclk) disable iff (!presetn) // R18
    st_done && op_rx && rx_n_reg != 4'h0 |=> tx_buf[0] == ~$past(rx_buf[0]))
    else $error("send buffer not complemented");
  a_rearm_ready: assert property (@(posedge pclk) disable iff (!presetn) // R19
    st_done && selected && ctrl_en_reg |=> st_cmd && !busy_out && busy_oe)
    else $error("not rearmed after data phase");
endmodule

// ---- test/scsh_master_model.sv ----
// Behavioural serial master that faces the command slave.
// Assumes the bench resolves the slave's data and busy pins to Z when undriven.
`include "scsh_params.svh"
module scsh_master_model (
  // Clock
  input wire logic pclk,
  // Slave side pins, already resolved
  input wire logic sdo_pin,
  input wire logic busy_pin,
  // Master driven pins
  output scsh_pkg::scsh_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_seen;
  initial
  begin
    pins = `SCSH_PIN_RST;
    busy_seen = 1'b0;
  end
  // ---------------------------------------------------------------
  // Select and handshake
  // ---------------------------------------------------------------
  task automatic sel(input logic level);
    @(posedge pclk);
    pins.csn <= level;
  endtask
  // Pad first: busy may still be low from the data phase before DONE
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    repeat (4) @(posedge pclk);
    for (int n = 0; n < 200 && !ok; n++)
    begin
      @(posedge pclk);
      ok = (busy_pin === 1'b0);
    end
  endtask
  // ---------------------------------------------------------------
  // One frame; 6 low plus 6 or 7 high cycles, about 125 ns a bit
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge pclk);
      pins.sclk <= 1'b0;
      pins.sdi <= tx[i];
      repeat (6) @(posedge pclk);
      pins.sclk <= 1'b1;
      rx[i] = sdo_pin;
      if (i == 0)
        busy_seen = busy_pin;
      repeat (5 + (i % 2)) @(posedge pclk);
    end
    // Released data line toggles so a stale bit is never mistaken
    @(posedge pclk);
    pins.sdi <= ~pins.sdi;
  endtask
endmodule

// ---- test/scsh_slave_test.sv ----
// Self-checking bench for the serial command slave.
// Assumes the slave module, its package and the master model are compiled first.
`include "scsh_params.svh"
module scsh_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sdo;
  logic sdo_oe;
  logic busy;
  logic busy_oe;
  scsh_pkg::scsh_pins_t pins;
  wire logic sdo_pin = sdo_oe ? sdo : 1'bz;
  wire logic busy_pin = busy_oe ? busy : 1'bz;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] pat [0:7] = '{8'h01, 8'hC8, 8'h35, 8'hE2, 8'h7A, 8'h0D, 8'hB6, 8'h93};
  always #5 pclk = ~pclk;
  scsh_slave scsh_slave_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(pins.sclk), .serial_data_in(pins.sdi), .select_n(pins.csn),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .busy_out(busy), .busy_oe(busy_oe)
  );
  scsh_master_model scsh_master_model_i (
    .pclk(pclk), .sdo_pin(sdo_pin), .busy_pin(busy_pin), .pins(pins)
  );
  // ---------------------------------------------------------------
  // Shared checks and bus cycles
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check($sformatf("reg %h", a), r & mask, exp);
  endtask
  task automatic ready(input string what);
    logic ok;
    scsh_master_model_i.wait_ready(ok);
    check(what, ok, 1'b1);
  endtask
  task automatic xchk(input logic [7:0] tx, input logic [7:0] exp, input logic bexp);
    logic [7:0] rx;
    scsh_master_model_i.xfer(tx, rx);
    check("rx byte", rx, exp);
    check("busy at last rise", scsh_master_model_i.busy_seen, bexp);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_idle;
    logic [31:0] r;
    logic e;
    check("busy pin idle", busy_pin, 1'bz);
    check("data pin idle", sdo_pin, 1'bz);
    rd(`SCSH_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0010);
    rd(`SCSH_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000, r, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", r, 32'h0000_0000);
  endtask
  task automatic t_status;
    wr(`SCSH_OFF_TXCNT, 32'h0000_0005);
    scsh_master_model_i.sel(1'b0);
    ready("ready on select");
    xchk(`SCSH_CMD_STATUS, `SCSH_FILL_BYTE, 1'b1);
    ready("ready after command");
    xchk(8'h00, 8'h45, 1'b0);
    xchk(8'h00, 8'h08, 1'b0);
    ready("rearm after status");
  endtask
  task automatic t_write;
    xchk(8'h83, `SCSH_FILL_BYTE, 1'b1);
    ready("ready for data");
    for (int i = 0; i < 3; i++)
      xchk(pat[i], `SCSH_FILL_BYTE, 1'b0);
    ready("rearm after write");
    scsh_master_model_i.sel(1'b1);
    for (int i = 0; i < 3; i++)
    begin
      rd({`SCSH_WIN_RX, 3'(i), 2'h0}, 32'hFFFF_FFFF, {24'h0, pat[i]});
      rd({`SCSH_WIN_TX, 3'(i), 2'h0}, 32'hFFFF_FFFF, {24'h0, ~pat[i]});
    end
    rd(`SCSH_OFF_TXCNT, 32'hFFFF_FFFF, 32'h0000_0003);
    rd(`SCSH_OFF_STATUS, 32'hFFFF_FFFF, 32'h0083_3010);
  endtask
  task automatic t_read;
    for (int i = 0; i < 8; i++)
      wr({`SCSH_WIN_TX, 3'(i), 2'h0}, {24'h0, pat[i]});
    scsh_master_model_i.sel(1'b0);
    ready("ready on reselect");
    xchk(8'h48, `SCSH_FILL_BYTE, 1'b1);
    ready("ready for read data");
    for (int i = 0; i < 8; i++)
      xchk(8'h00, pat[i], 1'b0);
    ready("rearm after read");
  endtask
  task automatic t_duplex;
    xchk(8'hC2, `SCSH_FILL_BYTE, 1'b1);
    ready("ready for duplex");
    xchk(8'h5A, pat[0], 1'b0);
    xchk(8'h3C, pat[1], 1'b0);
    ready("rearm after duplex");
    rd({`SCSH_WIN_RX, 3'h1, 2'h0}, 32'hFFFF_FFFF, 32'h0000_003C);
    rd({`SCSH_WIN_TX, 3'h0, 2'h0}, 32'hFFFF_FFFF, 32'h0000_00A5);
    rd({`SCSH_WIN_TX, 3'h1, 2'h0}, 32'hFFFF_FFFF, 32'h0000_00C3);
  endtask
  // Deselect in mid data phase, then a fresh selection must work
  task automatic t_abort;
    logic [7:0] rx;
    xchk(8'h84, `SCSH_FILL_BYTE, 1'b1);
    ready("ready before abort");
    scsh_master_model_i.xfer(8'h11, rx);
    scsh_master_model_i.sel(1'b1);
    repeat (8) @(posedge pclk);
    check("busy pin released", busy_pin, 1'bz);
    check("data pin released", sdo_pin, 1'bz);
    rd(`SCSH_OFF_STATUS, 32'h0000_01F0, 32'h0000_0010);
    scsh_master_model_i.sel(1'b0);
    ready("ready after abort");
    xchk(`SCSH_CMD_STATUS, `SCSH_FILL_BYTE, 1'b1);
    scsh_master_model_i.sel(1'b1);
  endtask
  // Disabled channel ignores select; op 00 with a count only rearms
  task automatic t_disable;
    wr(`SCSH_OFF_CTRL, 32'h0000_0000);
    scsh_master_model_i.sel(1'b0);
    repeat (8) @(posedge pclk);
    check("busy pin disabled", busy_pin, 1'bz);
    check("data pin disabled", sdo_pin, 1'bz);
    rd(`SCSH_OFF_STATUS, 32'h0000_01F0, 32'h0000_0010);
    scsh_master_model_i.sel(1'b1);
    wr(`SCSH_OFF_CTRL, 32'h0000_0001);
    rd(`SCSH_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    scsh_master_model_i.sel(1'b0);
    ready("ready after enable");
    xchk(8'h05, `SCSH_FILL_BYTE, 1'b1);
    ready("rearm after no-op");
    rd(`SCSH_OFF_STATUS, 32'h00FF_01F3, 32'h0005_0021);
    scsh_master_model_i.sel(1'b1);
  endtask
  // ---------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_idle;
    t_status;
    t_write;
    t_read;
    t_duplex;
    t_abort;
    t_disable;
    final_report;
  end
  // Whole run needs a few thousand cycles; limit is 20000
  initial
  begin
    #200_000;
    miscompares++;
    final_report;
  end
endmodule
